// *** hw/tcts_core.v ***
`timescale 1ns/1ps
`include "tcts_consts.vh"
module tcts_core #(
   parameter TICK_CYC   = `TCTS_TICK_NS / `TCTS_CLK_NS,
   parameter DECEL_STEP = 14'h0064
) (
   input  wire        CLK,
   input  wire        RESET_N,
   input  wire [8:0]  AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   output reg  [31:0] AVS_READDATA,
   output wire        AVS_WAITREQUEST,
   input  wire        DATA_SELECT_BIT0,
   input  wire        DATA_SELECT_BIT1,
   input  wire        DATA_SELECT_BIT2,
   input  wire        FORWARD_RUN_INPUT,
   input  wire        REVERSE_RUN_INPUT,
   input  wire [15:0] ANALOG_MV,
   input  wire [9:0]  ROLL_DIAM,
   output reg  [13:0] TENS_CMD,
   output reg         TENS_DIR,
   output reg         RUNNING,
   output reg         STOPPING,
   output reg         WINDING
);
   localparam ST_IDLE = 2'b00;
   localparam ST_RUN  = 2'b01;
   localparam ST_DEC  = 2'b10;
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [3:0]  pin_a_r;
   reg [3:0]  pin_b_r;
   always @(posedge CLK) begin
      if (!RESET_N) begin
         pin_a_r <= 4'h0;
         pin_b_r <= 4'h0;
      end else begin
         pin_a_r <= {FORWARD_RUN_INPUT, DATA_SELECT_BIT2, DATA_SELECT_BIT1, DATA_SELECT_BIT0};
         pin_b_r <= pin_a_r;
      end
   end
   // reverse ignored: REVERSE_RUN_INPUT is deliberately left unread
   wire       fwd_run = pin_b_r[3];
   wire [2:0] sel_pins = pin_b_r[2:0];
   // ----------------------------------------
   // bus slave, one wait cycle per access
   // ----------------------------------------
   reg        ack_r;
   wire       req = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = req & ~ack_r;
   wire       wr_go = AVS_WRITE & ack_r;
   wire       in_set = AVS_ADDRESS[`TCTS_SET_BIT];
   wire [2:0] a_set = AVS_ADDRESS[7:5];
   wire [2:0] a_fld = AVS_ADDRESS[4:2];
   wire [31:0] wd = AVS_WRITEDATA;
   always @(posedge CLK) begin
      if (!RESET_N)
         ack_r <= 1'b0;
      else
         ack_r <= req & ~ack_r;
   end
   function [12:0] clampu;
      input [31:0] v;
      input [12:0] lo;
      input [12:0] hi;
      begin
         if (v < {19'h0, lo})
            clampu = lo;
         else if (v > {19'h0, hi})
            clampu = hi;
         else
            clampu = v[12:0];
      end
   endfunction
   // clamped write values, cut to each field's width at the point of use
   wire [12:0] pct_c  = clampu(wd, 13'h0000, {6'h00, `TCTS_MAX_PCT});
   wire [12:0] diam_c = clampu(wd, 13'h0001, {3'h0, `TCTS_MAX_DIAM});
   // ----------------------------------------
   // global parameters
   // ----------------------------------------
   reg        ana_stg_r;
   reg        dir_stg_r;
   reg        mode2_stg_r;
   reg        ana_r;
   reg        dir_r;
   reg        mode2_r;
   reg        auto_r;
   reg        boot_r;
   reg [6:0]  gain_r;
   reg [15:0] offs_r;
   reg [15:0] autoref_r;
   wire       ctl_wr = wr_go & ~in_set & (AVS_ADDRESS == `TCTS_A_CTRL);
   always @(posedge CLK) begin
      if (!RESET_N) begin
         ana_stg_r   <= 1'b1;
         dir_stg_r   <= 1'b1;
         mode2_stg_r <= 1'b0;
         ana_r       <= 1'b1;
         dir_r       <= 1'b1;
         mode2_r     <= 1'b0;
         auto_r      <= 1'b0;
         boot_r      <= 1'b1;
         gain_r      <= `TCTS_RST_GAIN;
         offs_r      <= 16'h0000;
         autoref_r   <= 16'h0000;
      end else begin
         // system parameters latched once at start-up or a software restart
         boot_r <= ctl_wr & wd[`TCTS_C_RELOAD];
         if (boot_r) begin
            ana_r   <= ana_stg_r;
            dir_r   <= dir_stg_r;
            mode2_r <= mode2_stg_r;
         end
         if (ctl_wr) begin
            ana_stg_r   <= wd[`TCTS_C_ANA];
            dir_stg_r   <= wd[`TCTS_C_DIR];
            mode2_stg_r <= wd[`TCTS_C_MODE2];
            auto_r      <= wd[`TCTS_C_AUTO];
         end
         // capture the 0 V reading on apply, only if auto was already set by an earlier control write
         if (ctl_wr & wd[`TCTS_C_APPLY] & auto_r)
            autoref_r <= ANALOG_MV;
         if (wr_go & ~in_set & (AVS_ADDRESS == `TCTS_A_GAIN))
            gain_r <= pct_c[6:0];
         if (wr_go & ~in_set & (AVS_ADDRESS == `TCTS_A_OFFS))
            offs_r <= wd[15:0];
      end
   end
   // ----------------------------------------
   // operation data sets
   // ----------------------------------------
   reg  [15:0] ds_cmd   [0:7];
   reg  [12:0] ds_thick [0:7];
   reg  [9:0]  ds_init  [0:7];
   reg  [9:0]  ds_final [0:7];
   reg  [6:0]  ds_taper [0:7];
   reg  [23:0] ds_matj  [0:7];
   reg  [23:0] ds_corej [0:7];
   wire [23:0] j_in = (wd > {8'h00, `TCTS_MAX_J}) ? `TCTS_MAX_J : wd[23:0];
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_set
         wire hit = wr_go & in_set & (a_set == gi);
         always @(posedge CLK) begin
            if (!RESET_N) begin
               ds_cmd[gi]   <= 16'h0000;
               ds_thick[gi] <= `TCTS_RST_THICK;
               ds_init[gi]  <= `TCTS_RST_INIT;
               ds_final[gi] <= `TCTS_RST_FINAL;
               ds_taper[gi] <= `TCTS_RST_TAPER;
               ds_matj[gi]  <= 24'h000000;
               ds_corej[gi] <= 24'h000000;
            end else if (hit) begin
               if (a_fld == `TCTS_F_CMD)
                  ds_cmd[gi] <= wd[15:0];
               // stored values held inside their ranges
               if (a_fld == `TCTS_F_THICK)
                  ds_thick[gi] <= clampu(wd, 13'h0001, `TCTS_MAX_THICK);
               if (a_fld == `TCTS_F_INIT)
                  ds_init[gi] <= diam_c[9:0];
               if (a_fld == `TCTS_F_FINAL)
                  ds_final[gi] <= diam_c[9:0];
               if (a_fld == `TCTS_F_TAPER)
                  ds_taper[gi] <= pct_c[6:0];
               // inertia only writable in the second mode
               if ((a_fld == `TCTS_F_MATJ) & mode2_r)
                  ds_matj[gi] <= j_in;
               if ((a_fld == `TCTS_F_COREJ) & mode2_r)
                  ds_corej[gi] <= j_in;
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // selection and command source
   // ----------------------------------------
   reg  [1:0]  state_r;
   reg  [2:0]  sel_hold_r;
   wire [2:0]  sel = (state_r == ST_RUN) ? sel_hold_r : sel_pins;
   wire [15:0] zero_ref = auto_r ? autoref_r : offs_r;
   // gain times (voltage minus offset), result in 0.01 %
   wire signed [16:0] vdiff = $signed({ANALOG_MV[15], ANALOG_MV}) - $signed({zero_ref[15], zero_ref});
   wire signed [24:0] aprod = $signed({1'b0, gain_r}) * vdiff;
   wire signed [24:0] a_cmd = aprod / 25'sd10;
   wire signed [24:0] d_cmd = $signed({{9{ds_cmd[sel][15]}}, ds_cmd[sel]}) * 25'sd100;
   reg  signed [24:0] raw_cmd;
   always @* begin
      raw_cmd = d_cmd;
      if (ana_r) begin
         // set 1 follows the external voltage
         if (sel == 3'h1)
            raw_cmd = a_cmd;
         // set 0 belongs to the trim pot, which this block does not carry
         else if (sel == 3'h0)
            raw_cmd = 25'sd0;
      end
   end
   wire        neg = raw_cmd[24];
   wire [24:0] mag = neg ? (25'd0 - raw_cmd) : raw_cmd;
   // clamp to 100 %, taper never raises it
   wire [13:0] mag_c = (mag > {11'h000, `TCTS_FULL_CMD}) ? `TCTS_FULL_CMD : mag[13:0];
   // ----------------------------------------
   // winding decision and taper
   // ----------------------------------------
   wire [9:0]  d_init = ds_init[sel];
   wire [9:0]  d_fin  = ds_final[sel];
   // winding when initial below final; equal counts as winding
   wire        wind = (d_init <= d_fin);
   wire [9:0]  d_max = wind ? d_fin : d_init;
   // diameter taken from ROLL_DIAM, capped at the maximum, so the taper is live from the first cycle
   wire [9:0]  d_now = (ROLL_DIAM > d_max) ? d_max : ROLL_DIAM;
   wire [6:0]  tap = ds_taper[sel];
   // linear from full at zero to taper at maximum
   wire [16:0] t_den = d_max * 7'd100;
   wire [16:0] t_num = t_den - (7'd100 - tap) * d_now;
   wire [30:0] t_prod = mag_c * t_num;
   // taper 100 leaves the command untouched
   wire [30:0] t_res = (tap == `TCTS_MAX_PCT) ? {17'h0, mag_c} : t_prod / t_den;
   wire [13:0] tcmd = t_res[13:0];
   // ----------------------------------------
   // run sequencer
   // ----------------------------------------
   reg [16:0] tick_cnt_r;
   wire       tick = (tick_cnt_r == TICK_CYC - 1);
   always @(posedge CLK) begin
      if (!RESET_N)
         tick_cnt_r <= 17'h00000;
      else if (tick)
         tick_cnt_r <= 17'h00000;
      else
         tick_cnt_r <= tick_cnt_r + 17'h00001;
   end
   reg  [1:0]  state_nxt;
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (fwd_run)
               state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (!fwd_run)
               state_nxt = ST_DEC;
         end
         ST_DEC: begin
            if (fwd_run)
               state_nxt = ST_RUN;
            else if (TENS_CMD == 14'h0000)
               state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end
   always @(posedge CLK) begin
      if (!RESET_N) begin
         state_r    <= ST_IDLE;
         sel_hold_r <= 3'h0;
         TENS_CMD   <= 14'h0000;
         TENS_DIR   <= 1'b0;
         RUNNING    <= 1'b0;
         STOPPING   <= 1'b0;
         WINDING    <= 1'b1;
      end else begin
         state_r  <= state_nxt;
         RUNNING  <= (state_nxt == ST_RUN);
         STOPPING <= (state_nxt == ST_DEC);
         // latch the set as run begins
         if (state_r != ST_RUN)
            sel_hold_r <= sel_pins;
         if (state_nxt == ST_RUN) begin
            TENS_CMD <= tcmd;
            WINDING  <= wind;
            TENS_DIR <= dir_r ^ neg;
         end else if ((state_r == ST_DEC) & tick) begin
            // ramp down; the real stop time depends on the load
            if (TENS_CMD > DECEL_STEP)
               TENS_CMD <= TENS_CMD - DECEL_STEP;
            else
               TENS_CMD <= 14'h0000;
         end
      end
   end
   // ----------------------------------------
   // read data
   // ----------------------------------------
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = 32'h00000000;
      if (in_set) begin
         case (a_fld)
            `TCTS_F_CMD:   rd_nxt = {{16{ds_cmd[a_set][15]}}, ds_cmd[a_set]};
            `TCTS_F_THICK: rd_nxt = {19'h0, ds_thick[a_set]};
            `TCTS_F_INIT:  rd_nxt = {22'h0, ds_init[a_set]};
            `TCTS_F_FINAL: rd_nxt = {22'h0, ds_final[a_set]};
            `TCTS_F_TAPER: rd_nxt = {25'h0, ds_taper[a_set]};
            `TCTS_F_MATJ:  rd_nxt = {8'h0, ds_matj[a_set]};
            `TCTS_F_COREJ: rd_nxt = {8'h0, ds_corej[a_set]};
            default:       rd_nxt = 32'h00000000;
         endcase
      end else begin
         case (AVS_ADDRESS)
            `TCTS_A_CTRL:    rd_nxt = {26'h0, 2'b00, auto_r, mode2_stg_r, dir_stg_r, ana_stg_r};
            `TCTS_A_GAIN:    rd_nxt = {25'h0, gain_r};
            `TCTS_A_OFFS:    rd_nxt = {{16{offs_r[15]}}, offs_r};
            `TCTS_A_STATUS:  rd_nxt = {20'h0, sel_hold_r, state_r, mode2_r, dir_r, ana_r,
                                       WINDING, TENS_DIR, STOPPING, RUNNING};
            `TCTS_A_AUTOREF: rd_nxt = {{16{autoref_r[15]}}, autoref_r};
            `TCTS_A_OUTCMD:  rd_nxt = {18'h0, TENS_CMD};
            default:         rd_nxt = 32'h00000000;
         endcase
      end
   end
   always @(posedge CLK) begin
      if (!RESET_N)
         AVS_READDATA <= 32'h00000000;
      else if (AVS_READ & ~ack_r)
         AVS_READDATA <= rd_nxt;
   end
endmodule

// *** hw/tcts_consts.vh ***
`ifndef TCTS_CONSTS_VH
`define TCTS_CONSTS_VH
// ----------------------------------------
// register word addresses (byte offsets)
// ----------------------------------------
`define TCTS_A_CTRL     9'h000
`define TCTS_A_GAIN     9'h004
`define TCTS_A_OFFS     9'h008
`define TCTS_A_STATUS   9'h00C
`define TCTS_A_AUTOREF  9'h010
`define TCTS_A_OUTCMD   9'h014
`define TCTS_SET_BIT    8
// ----------------------------------------
// control fields
// ----------------------------------------
`define TCTS_C_ANA      0
`define TCTS_C_DIR      1
`define TCTS_C_MODE2    2
`define TCTS_C_AUTO     3
`define TCTS_C_APPLY    4
`define TCTS_C_RELOAD   5
// ----------------------------------------
// data set fields
// ----------------------------------------
`define TCTS_F_CMD      3'h0
`define TCTS_F_THICK    3'h1
`define TCTS_F_INIT     3'h2
`define TCTS_F_FINAL    3'h3
`define TCTS_F_TAPER    3'h4
`define TCTS_F_MATJ     3'h5
`define TCTS_F_COREJ    3'h6
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define TCTS_RST_GAIN   7'h0A
`define TCTS_RST_THICK  13'h0032
`define TCTS_RST_INIT   10'h1F4
`define TCTS_RST_FINAL  10'h3E8
`define TCTS_RST_TAPER  7'h64
`define TCTS_MAX_THICK  13'h1388
`define TCTS_MAX_DIAM   10'h3E8
`define TCTS_MAX_PCT    7'h64
`define TCTS_MAX_J      24'h98967F
`define TCTS_FULL_CMD   14'h2710
`define TCTS_TICK_NS    1000000
`define TCTS_CLK_NS     10
`endif

// *** tb/tcts_monitor.sv ***
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module tcts_monitor #(
   parameter DECEL_STEP = 14'h0064
) (
   input wire        CLK,
   input wire        RESET_N,
   input wire [8:0]  AVS_ADDRESS,
   input wire        AVS_READ,
   input wire        AVS_WRITE,
   input wire [31:0] AVS_READDATA,
   input wire        AVS_WAITREQUEST,
   input wire        FORWARD_RUN_INPUT,
   input wire [13:0] TENS_CMD,
   input wire        RUNNING,
   input wire        STOPPING,
   input wire        WINDING
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   AST_BUS_ANSWER: assert property ($rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("bus answer not in second cycle");
   AST_UNMAPPED: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 9'h01C |-> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   AST_CLAMP: assert property (TENS_CMD <= 14'h2710)
      else $error("command above full scale");
   AST_EXCL: assert property (!(RUNNING && STOPPING))
      else $error("run and stop together");
   AST_RUN_START: assert property ($rose(FORWARD_RUN_INPUT) ##1 FORWARD_RUN_INPUT [*2] |-> ##[1:2] RUNNING)
      else $error("run not started");
   AST_RUN_STOP: assert property ($fell(FORWARD_RUN_INPUT) ##1 !FORWARD_RUN_INPUT [*2] |-> ##[1:2] !RUNNING)
      else $error("run not left");
   AST_DECEL: assert property (STOPPING && $past(STOPPING) |->
      TENS_CMD <= $past(TENS_CMD) && ($past(TENS_CMD) - TENS_CMD) <= DECEL_STEP)
      else $error("deceleration step wrong");
   AST_IDLE_ZERO: assert property (!RUNNING && !STOPPING |-> TENS_CMD == 14'h0000)
      else $error("idle command not zero");
   AST_WIND_HOLD: assert property (!RUNNING && !$past(RUNNING) |-> $stable(WINDING))
      else $error("winding changed while idle");
   cover property ($rose(RUNNING));
   cover property ($fell(STOPPING));
   cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule

bind tcts_core tcts_monitor #(.DECEL_STEP(DECEL_STEP)) u_mon (
   .CLK               (CLK),
   .RESET_N           (RESET_N),
   .AVS_ADDRESS       (AVS_ADDRESS),
   .AVS_READ          (AVS_READ),
   .AVS_WRITE         (AVS_WRITE),
   .AVS_READDATA      (AVS_READDATA),
   .AVS_WAITREQUEST   (AVS_WAITREQUEST),
   .FORWARD_RUN_INPUT (FORWARD_RUN_INPUT),
   .TENS_CMD          (TENS_CMD),
   .RUNNING           (RUNNING),
   .STOPPING          (STOPPING),
   .WINDING           (WINDING)
);

// *** tb/tcts_host.sv ***
`timescale 1ns/1ps
module tcts_host (
   input  wire       CLK,
   input  wire [2:0] sel_req,
   input  wire       run_req,
   input  wire       rev_req,
   output reg        DATA_SELECT_BIT0,
   output reg        DATA_SELECT_BIT1,
   output reg        DATA_SELECT_BIT2,
   output reg        FORWARD_RUN_INPUT,
   output reg        REVERSE_RUN_INPUT
);
   // pins change only on the clock edge
   always @(posedge CLK) begin
      {DATA_SELECT_BIT2, DATA_SELECT_BIT1, DATA_SELECT_BIT0} <= sel_req;
      FORWARD_RUN_INPUT <= run_req;
      REVERSE_RUN_INPUT <= rev_req;
   end
endmodule

// *** tb/tension_command_taper_select_tb.sv ***
`timescale 1ns/1ps
`include "tcts_consts.vh"
module tension_command_taper_select_tb;
   reg               CLK = 1'b0;
   reg               RESET_N = 1'b0;
   reg        [8:0]  addr = 9'h000;
   reg               rd = 1'b0;
   reg               wr = 1'b0;
   reg        [31:0] wdata = 32'h0;
   reg        [2:0]  sel_req = 3'h0;
   reg               run_req = 1'b0;
   reg               rev_req = 1'b0;
   reg signed [15:0] mv = 16'sh0000;
   reg        [9:0]  diam = 10'h1F4;
   wire       [31:0] rdata;
   wire              wait_req, s0, s1, s2, fwd, rev, dir, running, stopping, winding;
   wire       [13:0] cmd;
   integer           failures = 0;
   integer           check_count = 0;
   reg        [31:0] q;

   initial forever #5 CLK = ~CLK;

   tcts_host HOST (.CLK(CLK), .sel_req(sel_req), .run_req(run_req), .rev_req(rev_req), .DATA_SELECT_BIT0(s0),
      .DATA_SELECT_BIT1(s1), .DATA_SELECT_BIT2(s2), .FORWARD_RUN_INPUT(fwd), .REVERSE_RUN_INPUT(rev));
   tcts_core #(.TICK_CYC(4), .DECEL_STEP(14'h0064)) DUT (.CLK(CLK), .RESET_N(RESET_N), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
      .DATA_SELECT_BIT0(s0), .DATA_SELECT_BIT1(s1), .DATA_SELECT_BIT2(s2), .FORWARD_RUN_INPUT(fwd),
      .REVERSE_RUN_INPUT(rev), .ANALOG_MV(mv), .ROLL_DIAM(diam), .TENS_CMD(cmd), .TENS_DIR(dir),
      .RUNNING(running), .STOPPING(stopping), .WINDING(winding));

   // ------------------------------
   // helpers
   // ------------------------------
   function [8:0] da(input [2:0] s, input [2:0] f);
      da = 9'h100 + {s, 5'h00} + {f, 2'b00};
   endfunction
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // waits for waitrequest low; read data is taken at that same edge
   task bus(input w, input [8:0] a, input [31:0] d);
      begin
         @(posedge CLK);
         addr <= a; wdata <= d; rd <= !w; wr <= w;
         // only the watchdog ends a hung wait
         do @(posedge CLK); while (wait_req !== 1'b0);
         q = rdata;
         rd <= 1'b0; wr <= 1'b0;
      end
   endtask
   task wreg(input [8:0] a, input [31:0] d); bus(1'b1, a, d); endtask
   task rchk(input string nm, input [8:0] a, input [31:0] e);
      begin bus(1'b0, a, 32'h0); chk(nm, e, q); end
   endtask
   task go(input [2:0] s, input [31:0] e, input e_dir);
      begin
         @(posedge CLK); sel_req <= s;
         repeat (4) @(posedge CLK);
         run_req <= 1'b1;
         repeat (8) @(posedge CLK);
         chk("tens cmd", e, cmd);
         chk("tens dir", e_dir, dir);
      end
   endtask
   task stop;
      integer n;
      begin
         run_req <= 1'b0;
         n = 0;
         repeat (5) @(posedge CLK);
         chk("stopping", 1, stopping);
         while ((running | stopping) !== 1'b0 && n < 3000) begin @(posedge CLK); n = n + 1; end
         chk("stopped", 0, running | stopping);
         chk("idle cmd", 0, cmd);
      end
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   task t_regs;
      begin
         rchk("gain", `TCTS_A_GAIN, 32'h0A);
         rchk("thick", da(7, `TCTS_F_THICK), 32'h32);
         rchk("init", da(7, `TCTS_F_INIT), 32'h1F4);
         rchk("final", da(7, `TCTS_F_FINAL), 32'h3E8);
         rchk("taper", da(7, `TCTS_F_TAPER), 32'h64);
         rchk("unmapped", 9'h01C, 32'h0);
         wreg(`TCTS_A_GAIN, 32'hC8);
         rchk("gain max", `TCTS_A_GAIN, 32'h64);
         wreg(`TCTS_A_GAIN, 32'h0A);
         wreg(da(1, `TCTS_F_THICK), 32'h1770);
         rchk("thick max", da(1, `TCTS_F_THICK), 32'h1388);
         wreg(da(1, `TCTS_F_MATJ), 32'h5);
         rchk("mat j", da(1, `TCTS_F_MATJ), 32'h0);
         $display("t_regs done");
      end
   endtask
   task t_digital;
      begin
         wreg(da(3, `TCTS_F_CMD), 32'h28);
         wreg(da(6, `TCTS_F_CMD), 32'h96);
         wreg(da(4, `TCTS_F_CMD), 32'hFFFFFFE2);
         go(3, 32'hFA0, 1'b1);
         @(posedge CLK); sel_req <= 3'h6;
         repeat (8) @(posedge CLK);
         chk("held set", 32'hFA0, cmd);
         stop;
         go(6, 32'h2710, 1'b1);
         stop;
         go(4, 32'hBB8, 1'b0);
         stop;
         run_req <= 1'b0; rev_req <= 1'b1;
         repeat (8) @(posedge CLK);
         chk("reverse ignored", 0, running);
         rev_req <= 1'b0;
         $display("t_digital done");
      end
   endtask
   task t_analog;
      begin
         wreg(`TCTS_A_OFFS, 32'h3E8);
         mv <= 16'sd5000;
         go(1, 32'hFA0, 1'b1);
         stop;
         go(0, 32'h0, 1'b1);
         stop;
         mv <= 16'sd200;
         wreg(`TCTS_A_CTRL, 32'h0B);
         wreg(`TCTS_A_CTRL, 32'h1B);
         rchk("auto ref", `TCTS_A_AUTOREF, 32'hC8);
         mv <= 16'sd5200;
         go(1, 32'h1388, 1'b1);
         stop;
         $display("t_analog done");
      end
   endtask
   task t_taper;
      begin
         wreg(da(2, `TCTS_F_CMD), 32'h50);
         wreg(da(2, `TCTS_F_TAPER), 32'h32);
         go(2, 32'h1770, 1'b1);
         chk("winding", 1, winding);
         diam <= 10'h3E8;
         repeat (4) @(posedge CLK);
         chk("taper at max", 32'hFA0, cmd);
         stop;
         wreg(da(5, `TCTS_F_CMD), 32'h50);
         wreg(da(5, `TCTS_F_TAPER), 32'h32);
         wreg(da(5, `TCTS_F_INIT), 32'h320);
         wreg(da(5, `TCTS_F_FINAL), 32'h12C);
         diam <= 10'h190;
         go(5, 32'h1770, 1'b1);
         chk("unwinding", 0, winding);
         stop;
         $display("t_taper done");
      end
   endtask
   task t_reload;
      begin
         wreg(`TCTS_A_CTRL, 32'h02);
         bus(1'b0, `TCTS_A_STATUS, 32'h0);
         chk("analog still on", 1, q[4]);
         go(1, 32'h1068, 1'b1);
         stop;
         wreg(`TCTS_A_CTRL, 32'h20);
         repeat (4) @(posedge CLK);
         bus(1'b0, `TCTS_A_STATUS, 32'h0);
         chk("analog off", 0, q[4]);
         wreg(da(0, `TCTS_F_CMD), 32'h19);
         go(0, 32'h9C4, 1'b0);
         stop;
         wreg(`TCTS_A_CTRL, 32'h24);
         wreg(da(1, `TCTS_F_MATJ), 32'h01000000);
         rchk("mat j max", da(1, `TCTS_F_MATJ), 32'h98967F);
         wreg(da(2, `TCTS_F_COREJ), 32'h5);
         rchk("core j", da(2, `TCTS_F_COREJ), 32'h5);
         $display("t_reload done");
      end
   endtask

   task final_report;
      begin
         $display("checks %0d mismatches %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   initial begin
      repeat (16) @(posedge CLK);
      RESET_N <= 1'b1;
      t_regs;
      t_digital;
      t_analog;
      t_taper;
      t_reload;
      final_report;
   end
   initial begin
      #600000;
      failures = failures + 1;
      final_report;
   end
endmodule
